/* design/vls_pkg.sv */
// package: system register encodings, field positions and sizes for the list status block
package vls_pkg;
    localparam logic [2:0] OP1_HYP        = 3'h4;
    localparam logic [3:0] CRN_VIRT       = 4'hC;
    localparam logic [3:0] CRM_AP1        = 4'h9;
    localparam logic [3:0] CRM_STATUS     = 4'hB;
    localparam logic [2:0] OP2_EOI_STAT   = 3'h3;
    localparam logic [2:0] OP2_EMPTY_STAT = 3'h5;
    localparam int         AP_INST_BIT    = 2;
    localparam int         MAX_ENTRIES    = 16;
    localparam int         AP_INSTANCES   = 4;
    localparam int         REG_W          = 32;
    localparam logic [31:0] AP_RESET      = 32'h0000_0000;
    localparam logic [1:0] STATE_INVALID  = 2'h0;
    localparam int         PRIO_BITS_MIN  = 5;
    localparam int         PRIO_BITS_AP1  = 6;
    localparam int         PRIO_BITS_MAX  = 7;
    localparam int         PRIO_MSB       = 7;
    localparam int         LEVEL_IDX_W    = 5;
    localparam int         INST_IDX_W     = 2;
    // access source level
    localparam logic [1:0] LEVEL_HYP      = 2'h2;
    localparam logic [1:0] LEVEL_MONITOR  = 2'h3;
endpackage : vls_pkg

/* design/vls_entry_status.sv */
// per-entry derivation of the two list status vectors
`timescale 1ns/1ps
module vls_entry_status #(
    parameter int NUM_ENTRIES = 16
) (
    // list entry fields
    input  wire logic [2*NUM_ENTRIES-1:0] i_state,
    input  wire logic [NUM_ENTRIES-1:0]   i_hw_link,
    input  wire logic [NUM_ENTRIES-1:0]   i_notify,
    // derived status
    output logic      [NUM_ENTRIES-1:0]   o_eoi_maint,
    output logic      [NUM_ENTRIES-1:0]   o_empty
);
    genvar g;
    generate
        for (g = 0; g < NUM_ENTRIES; g++) begin : g_entry
            logic idle;
            assign idle = (i_state[2*g +: 2] == vls_pkg::STATE_INVALID);
            assign o_eoi_maint[g] = idle & ~i_hw_link[g] & i_notify[g];
            assign o_empty[g]     = idle & (i_hw_link[g] | ~i_notify[g]);
        end
    endgenerate
endmodule : vls_entry_status

/* design/vls_top.sv */
// hypervisor list status and group 1 active-priority system registers
// Operation
// - group 1 active priorities are read-write at op1 100, CRn 1100, CRm 1001, op2 0:n.
// - instance 1 exists with 6+ priority bits, 2 and 3 only with 7.
// - hypervisor access traps when hypervisor sysreg enable is zero.
// - monitor access traps when monitor sysreg enable is zero.
// - maintenance status is 32 bits; bit n is entry n, upper bits zero.
// - maintenance bit set when state idle, no hardware link, notify set.
// - maintenance status is read-only at CRm 1011, op2 011.
// - empty bit set when state idle and hardware link or no notify.
// - empty bit zero while entry valid; bits 31:16 read zero.
// - empty status is read-only at CRm 1011, op2 101.
// - without hypervisor level, monitor reads zero and writes ignored.
// - priority bit is one while that level is active without priority drop.
// - five priority bits index 32 levels of instance 0 by bits 7:3.
// - reset clears every active-priority bit.
`timescale 1ns/1ps
module vls_top #(
    parameter int NUM_ENTRIES = 16,
    parameter int PRIO_BITS   = 5,
    parameter bit HYP_IMPL    = 1'b1
) (
    // clock and reset
    input  wire logic                     I_CLOCK,
    input  wire logic                     I_RST_N,
    // system register access from the core
    input  wire logic                     I_SR_VALID,
    input  wire logic                     I_SR_WRITE,
    input  wire logic [1:0]               I_SR_LEVEL,
    input  wire logic [2:0]               I_SR_OP1,
    input  wire logic [3:0]               I_SR_CRN,
    input  wire logic [3:0]               I_SR_CRM,
    input  wire logic [2:0]               I_SR_OP2,
    input  wire logic [31:0]              I_SR_WDATA,
    output logic      [31:0]              O_SR_RDATA,
    output logic                          O_SR_HIT,
    output logic                          O_SR_TRAP,
    output logic                          O_SR_UNDEF,
    // system register enables
    input  wire logic                     I_HYP_SYSREG_ENABLE,
    input  wire logic                     I_MONITOR_SYSREG_ENABLE,
    // priority activate and drop events
    input  wire logic                     I_PRIO_ACTIVATE,
    input  wire logic                     I_PRIO_DROP,
    input  wire logic [7:0]               I_PRIO_VALUE,
    // list entry fields
    input  wire logic [2*NUM_ENTRIES-1:0] I_ENTRY_STATE,
    input  wire logic [NUM_ENTRIES-1:0]   I_ENTRY_HW_LINK,
    input  wire logic [NUM_ENTRIES-1:0]   I_ENTRY_NOTIFY
);
    localparam int NUM_INST = (PRIO_BITS >= vls_pkg::PRIO_BITS_MAX) ? 4 :
                              (PRIO_BITS >= vls_pkg::PRIO_BITS_AP1) ? 2 : 1;

    logic [31:0]            ap1_word [vls_pkg::AP_INSTANCES];
    logic [NUM_ENTRIES-1:0] eoi_maint;
    logic [NUM_ENTRIES-1:0] empty;
    logic                   enc_base;
    logic                   is_ap1;
    logic                   is_eoi;
    logic                   is_empty;
    logic [1:0]             inst;
    logic                   inst_ok;
    logic                   trap;
    logic                   rz_wi;
    logic [1:0]             evt_inst;
    logic [4:0]             evt_bit;
    logic                   ap_write;

    vls_entry_status #(
        .NUM_ENTRIES (NUM_ENTRIES)
    ) u_status (
        .i_state     (I_ENTRY_STATE),
        .i_hw_link   (I_ENTRY_HW_LINK),
        .i_notify    (I_ENTRY_NOTIFY),
        .o_eoi_maint (eoi_maint),
        .o_empty     (empty)
    );

    // access decode
    assign enc_base = (I_SR_OP1 == vls_pkg::OP1_HYP) && (I_SR_CRN == vls_pkg::CRN_VIRT);
    assign is_ap1   = enc_base && (I_SR_CRM == vls_pkg::CRM_AP1)
                      && !I_SR_OP2[vls_pkg::AP_INST_BIT];
    assign is_eoi   = enc_base && (I_SR_CRM == vls_pkg::CRM_STATUS)
                      && (I_SR_OP2 == vls_pkg::OP2_EOI_STAT) && !I_SR_WRITE;
    assign is_empty = enc_base && (I_SR_CRM == vls_pkg::CRM_STATUS)
                      && (I_SR_OP2 == vls_pkg::OP2_EMPTY_STAT) && !I_SR_WRITE;
    assign inst     = I_SR_OP2[1:0];
    assign inst_ok  = (32'(inst) < 32'(NUM_INST));

    // traps win over everything else; a lower level never reaches here
    always_comb begin
        trap = 1'b0;
        if (I_SR_LEVEL == vls_pkg::LEVEL_HYP)
            trap = !I_HYP_SYSREG_ENABLE;
        else if (I_SR_LEVEL == vls_pkg::LEVEL_MONITOR)
            trap = !I_MONITOR_SYSREG_ENABLE;
    end
    assign rz_wi = !HYP_IMPL && (I_SR_LEVEL == vls_pkg::LEVEL_MONITOR);

    assign O_SR_HIT   = I_SR_VALID && !trap && ((is_ap1 && (inst_ok || rz_wi)) || is_eoi
                        || is_empty);
    assign O_SR_TRAP  = I_SR_VALID && trap && (is_ap1 || is_eoi || is_empty);
    assign O_SR_UNDEF = I_SR_VALID && !trap && is_ap1 && !inst_ok && !rz_wi;
    assign ap_write   = O_SR_HIT && is_ap1 && I_SR_WRITE && !rz_wi;

    // read data, combinational so the status follows the entries in the same cycle
    always_comb begin
        O_SR_RDATA = '0;
        if (O_SR_HIT && !I_SR_WRITE && !rz_wi) begin
            if (is_ap1)
                O_SR_RDATA = ap1_word[inst];
            else if (is_eoi)
                O_SR_RDATA = 32'(eoi_maint);
            else if (is_empty)
                O_SR_RDATA = 32'(empty);
        end
    end

    // priority level to instance and bit: top implemented bits select the word
    always_comb begin
        evt_inst = '0;
        evt_bit  = I_PRIO_VALUE[7:3];
        if (PRIO_BITS >= vls_pkg::PRIO_BITS_MAX) begin
            evt_inst = I_PRIO_VALUE[7:6];
            evt_bit  = I_PRIO_VALUE[5:1];
        end else if (PRIO_BITS >= vls_pkg::PRIO_BITS_AP1) begin
            evt_inst = {1'b0, I_PRIO_VALUE[7]};
            evt_bit  = I_PRIO_VALUE[6:2];
        end
    end

    // software write replaces the word; activate wins over drop and over the write
    genvar gi;
    generate
        for (gi = 0; gi < vls_pkg::AP_INSTANCES; gi++) begin : g_ap
            if (gi < NUM_INST) begin : g_impl
                // each word is its own register so the read mux sees one driver per word
                logic [31:0] word_ff;
                logic [31:0] nxt_word;
                always_comb begin
                    nxt_word = word_ff;
                    if (ap_write && (32'(inst) == gi))
                        nxt_word = I_SR_WDATA;
                    if (I_PRIO_DROP && (32'(evt_inst) == gi))
                        nxt_word[evt_bit] = 1'b0;
                    if (I_PRIO_ACTIVATE && (32'(evt_inst) == gi))
                        nxt_word[evt_bit] = 1'b1;
                end
                always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
                    if (!I_RST_N) begin
                        word_ff <= vls_pkg::AP_RESET;
                    end else begin
                        word_ff <= nxt_word;
                    end
                end
                assign ap1_word[gi] = word_ff;
            end else begin : g_none
                // missing instances hold no state; accesses to them are refused except monitor accesses without a hypervisor level, which read zero
                assign ap1_word[gi] = vls_pkg::AP_RESET;
            end
        end
    endgenerate

    // checks
    trap_hyp_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        I_SR_VALID && is_ap1 && I_SR_LEVEL == vls_pkg::LEVEL_HYP && !I_HYP_SYSREG_ENABLE
        |-> O_SR_TRAP && !O_SR_HIT) else $error("hyp access not trapped");
    trap_mon_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        I_SR_VALID && is_eoi && I_SR_LEVEL == vls_pkg::LEVEL_MONITOR
        && !I_MONITOR_SYSREG_ENABLE |-> O_SR_TRAP) else $error("monitor access not trapped");
    eoi_read_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        O_SR_HIT && is_eoi && !rz_wi |-> O_SR_RDATA[31:16] == 16'h0000
        && O_SR_RDATA[0] == (I_ENTRY_STATE[1:0] == 2'h0 && !I_ENTRY_HW_LINK[0]
        && I_ENTRY_NOTIFY[0])) else $error("maintenance status wrong");
    empty_read_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        O_SR_HIT && is_empty && !rz_wi && I_ENTRY_STATE[1:0] != 2'h0
        |-> O_SR_RDATA[0] == 1'b0 && O_SR_RDATA[31:16] == 16'h0000)
        else $error("empty status wrong");
    status_excl_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (eoi_maint & empty) == '0) else $error("entry both empty and pending eoi");
    ap_write_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        ap_write && inst == 2'h0 && !I_PRIO_ACTIVATE && !I_PRIO_DROP
        |=> ap1_word[0] == $past(I_SR_WDATA)) else $error("priority write lost");
    undef_inst_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        I_SR_VALID && !trap && is_ap1 && !rz_wi && 32'(inst) >= 32'(NUM_INST)
        |-> O_SR_UNDEF && !O_SR_HIT) else $error("missing instance not undefined");
    activate_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        I_PRIO_ACTIVATE && evt_inst == 2'h0 |=> ap1_word[0][$past(evt_bit)])
        else $error("active priority not set");
    rz_read_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        rz_wi |-> O_SR_RDATA == 32'h0000_0000 && !ap_write)
        else $error("monitor access without hyp not zero");
    drop_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        I_PRIO_DROP && !I_PRIO_ACTIVATE && evt_inst == 2'h0
        |=> !ap1_word[0][$past(evt_bit)])
        else $error("dropped priority still active");
    trap_data_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        O_SR_TRAP |-> O_SR_RDATA == 32'h0000_0000 && !O_SR_HIT && !O_SR_UNDEF)
        else $error("trapped access leaked data");
    empty_set_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        O_SR_HIT && is_empty && !rz_wi && I_ENTRY_STATE[1:0] == 2'h0
        && (I_ENTRY_HW_LINK[0] || !I_ENTRY_NOTIFY[0]) |-> O_SR_RDATA[0])
        else $error("free entry not reported empty");
    status_ro_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        I_SR_VALID && I_SR_WRITE && enc_base && I_SR_CRM == vls_pkg::CRM_STATUS
        |-> !O_SR_HIT) else $error("status register accepted a write");
    // a status write that hit would let software believe it cleared a bit
    cov_ap_w_c: cover property (@(posedge I_CLOCK) ap_write);
    cov_undef_c: cover property (@(posedge I_CLOCK) O_SR_UNDEF);
    cov_eoi_c:  cover property (@(posedge I_CLOCK) O_SR_HIT && is_eoi && O_SR_RDATA != 0);
    cov_emp_c:  cover property (@(posedge I_CLOCK) O_SR_HIT && is_empty);
    cov_trap_c: cover property (@(posedge I_CLOCK) O_SR_TRAP);
endmodule : vls_top

/* bench/vls_core_model.sv */
// core model issuing hypervisor system register accesses
`timescale 1ns/1ps
module vls_core_model (
    // clock
    input  wire logic        i_clk,
    // access request
    output logic             o_valid,
    output logic             o_write,
    output logic [1:0]       o_level,
    output logic [3:0]       o_crm,
    output logic [2:0]       o_op2,
    output logic [31:0]      o_wdata,
    // answer
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_hit,
    input  wire logic        i_trap,
    input  wire logic        i_undef
);
    initial begin
        o_valid = 1'b0;
        o_write = 1'b0;
        o_level = vls_pkg::LEVEL_HYP;
        o_crm   = 4'h0;
        o_op2   = 3'h0;
        o_wdata = 32'h0000_0000;
    end

    task automatic acc(input logic w, input logic [1:0] lv, input logic [3:0] cm,
                       input logic [2:0] o2, input logic [31:0] wd,
                       output logic [31:0] rd, output logic [2:0] fl);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_write <= w;
        o_level <= lv;
        o_crm   <= cm;
        o_op2   <= o2;
        o_wdata <= wd;
        // the answer is taken at the same rising edge at which the write lands
        @(posedge i_clk);
        rd = i_rdata;
        fl = {i_hit, i_trap, i_undef};
        o_valid <= 1'b0;
        // released data is inverted so a stale value is never mistaken for live
        o_wdata <= ~wd;
    endtask : acc
endmodule : vls_core_model

/* bench/vls_top_tb.sv */
// self-checking bench for the list status and active-priority registers
`timescale 1ns/1ps
module vls_top_tb;
    logic        clk, rst_n, valid, write, hyp_en, mon_en, act, drop, hit, trap, undef;
    logic [1:0]  level;
    logic [3:0]  crm;
    logic [2:0]  op2, fl;
    logic [7:0]  prio;
    logic [31:0] wdata, rdata, rd, state;
    logic [15:0] hw, ntf;
    int          n_errors, tests_run;
    localparam logic [1:0] HYP = vls_pkg::LEVEL_HYP;
    localparam logic [1:0] MON = vls_pkg::LEVEL_MONITOR;
    localparam logic [3:0] AP = vls_pkg::CRM_AP1;
    localparam logic [3:0] ST = vls_pkg::CRM_STATUS;
    logic [31:0] rz_rdata;
    logic        rz_hit;

    vls_top #(.NUM_ENTRIES(16), .PRIO_BITS(5), .HYP_IMPL(1'b1)) uut (
        .I_CLOCK(clk), .I_RST_N(rst_n), .I_SR_VALID(valid), .I_SR_WRITE(write),
        .I_SR_LEVEL(level), .I_SR_OP1(vls_pkg::OP1_HYP), .I_SR_CRN(vls_pkg::CRN_VIRT),
        .I_SR_CRM(crm), .I_SR_OP2(op2), .I_SR_WDATA(wdata), .O_SR_RDATA(rdata),
        .O_SR_HIT(hit), .O_SR_TRAP(trap), .O_SR_UNDEF(undef),
        .I_HYP_SYSREG_ENABLE(hyp_en), .I_MONITOR_SYSREG_ENABLE(mon_en),
        .I_PRIO_ACTIVATE(act), .I_PRIO_DROP(drop), .I_PRIO_VALUE(prio),
        .I_ENTRY_STATE(state), .I_ENTRY_HW_LINK(hw), .I_ENTRY_NOTIFY(ntf));
    // second copy without a hypervisor level, fed the same accesses
    vls_top #(.NUM_ENTRIES(16), .PRIO_BITS(5), .HYP_IMPL(1'b0)) uut_rz (
        .I_CLOCK(clk), .I_RST_N(rst_n), .I_SR_VALID(valid), .I_SR_WRITE(write),
        .I_SR_LEVEL(level), .I_SR_OP1(vls_pkg::OP1_HYP), .I_SR_CRN(vls_pkg::CRN_VIRT),
        .I_SR_CRM(crm), .I_SR_OP2(op2), .I_SR_WDATA(wdata), .O_SR_RDATA(rz_rdata),
        .O_SR_HIT(rz_hit), .O_SR_TRAP(), .O_SR_UNDEF(),
        .I_HYP_SYSREG_ENABLE(hyp_en), .I_MONITOR_SYSREG_ENABLE(mon_en),
        .I_PRIO_ACTIVATE(act), .I_PRIO_DROP(drop), .I_PRIO_VALUE(prio),
        .I_ENTRY_STATE(state), .I_ENTRY_HW_LINK(hw), .I_ENTRY_NOTIFY(ntf));
    vls_core_model core (.i_clk(clk), .o_valid(valid), .o_write(write), .o_level(level),
        .o_crm(crm), .o_op2(op2), .o_wdata(wdata), .i_rdata(rdata), .i_hit(hit),
        .i_trap(trap), .i_undef(undef));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            n_errors++;
        end
    endtask : chk

    task automatic pulse(input logic a, input logic d, input logic [7:0] p);
        @(posedge clk);
        act  <= a;
        drop <= d;
        prio <= p;
        @(posedge clk);
        act  <= 1'b0;
        drop <= 1'b0;
    endtask : pulse

    task automatic t_prio();
        core.acc(1'b0, HYP, AP, 3'h0, 32'h0, rd, fl);
        chk("ap1 reset", rd, 32'h0000_0000);
        chk("ap1 hit", {29'h0, fl}, 32'h0000_0004);
        pulse(1'b1, 1'b0, 8'h28);
        pulse(1'b1, 1'b0, 8'hF8);
        core.acc(1'b0, HYP, AP, 3'h0, 32'h0, rd, fl);
        chk("ap1 active", rd, 32'h8000_0020);
        pulse(1'b0, 1'b1, 8'h28);
        core.acc(1'b0, HYP, AP, 3'h0, 32'h0, rd, fl);
        chk("ap1 drop", rd, 32'h8000_0000);
        core.acc(1'b1, HYP, AP, 3'h0, 32'h0, rd, fl);
        core.acc(1'b0, HYP, AP, 3'h0, 32'h0, rd, fl);
        chk("ap1 write", rd, 32'h0000_0000);
        for (int n = 1; n < 4; n++) begin
            core.acc(1'b0, HYP, AP, n[2:0], 32'h0, rd, fl);
            chk("ap1 undef", {31'h0, fl[0]}, 32'h0000_0001);
        end
    endtask : t_prio

    task automatic t_trap();
        @(posedge clk);
        hyp_en <= 1'b0;
        core.acc(1'b0, HYP, ST, vls_pkg::OP2_EOI_STAT, 32'h0, rd, fl);
        chk("hyp trap", {31'h0, fl[1]}, 32'h0000_0001);
        chk("trap data", rd, 32'h0000_0000);
        core.acc(1'b0, MON, AP, 3'h0, 32'h0, rd, fl);
        chk("mon no trap", {31'h0, fl[1]}, 32'h0000_0000);
        @(posedge clk);
        hyp_en <= 1'b1;
        mon_en <= 1'b0;
        core.acc(1'b0, MON, AP, 3'h0, 32'h0, rd, fl);
        chk("mon trap", {31'h0, fl[1]}, 32'h0000_0001);
        core.acc(1'b0, HYP, AP, 3'h0, 32'h0, rd, fl);
        chk("hyp no trap", {31'h0, fl[1]}, 32'h0000_0000);
        @(posedge clk);
        mon_en <= 1'b1;
        core.acc(1'b1, MON, AP, 3'h0, 32'hFFFF_FFFF, rd, fl);
        core.acc(1'b0, MON, AP, 3'h0, 32'h0, rd, fl);
        chk("mon ap1 read", rd, 32'hFFFF_FFFF);
        chk("rz read", rz_rdata, 32'h0000_0000);
        chk("rz hit", {31'h0, rz_hit}, 32'h0000_0001);
        core.acc(1'b1, MON, AP, 3'h0, 32'h0, rd, fl);
    endtask : t_trap

    task automatic t_status();
        @(posedge clk);
        hw  <= 16'h00FF;
        ntf <= 16'h0F0F;
        core.acc(1'b0, HYP, ST, vls_pkg::OP2_EOI_STAT, 32'h0, rd, fl);
        chk("eoi stat", rd, 32'h0000_0F00);
        core.acc(1'b0, HYP, ST, vls_pkg::OP2_EMPTY_STAT, 32'h0, rd, fl);
        chk("empty stat", rd, 32'h0000_F0FF);
        @(posedge clk);
        state <= 32'h0001_0003;
        core.acc(1'b0, HYP, ST, vls_pkg::OP2_EOI_STAT, 32'h0, rd, fl);
        chk("eoi valid", rd, 32'h0000_0E00);
        core.acc(1'b0, HYP, ST, vls_pkg::OP2_EMPTY_STAT, 32'h0, rd, fl);
        chk("empty valid", rd, 32'h0000_F0FE);
        core.acc(1'b1, HYP, ST, vls_pkg::OP2_EOI_STAT, 32'hFFFF_FFFF, rd, fl);
        chk("status write", {29'h0, fl}, 32'h0000_0000);
    endtask : t_status

    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (2000) @(posedge clk);
        n_errors++;
        summarize();
    end

    initial begin
        {rst_n, act, drop, prio, state, hw, ntf} = '0;
        {hyp_en, mon_en} = 2'b11;
        n_errors = 0;
        tests_run = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_prio();
        t_trap();
        t_status();
        summarize();
    end
endmodule : vls_top_tb
